/* File: inc/dout_pkg.sv */
package dout_pkg;

    // ****************
    // Channel count and timing
    // ****************
    localparam int NUM_OUTPUTS      = 2;
    localparam int NUM_SOURCES      = 4;
    localparam int NUM_LIMITS       = 12;
    localparam int CLK_PERIOD_NS    = 50;
    localparam int NS_PER_MS        = 1000000;
    localparam int CYCLES_PER_MS    = NS_PER_MS / CLK_PERIOD_NS;

    // ****************
    // Register map (byte addresses)
    // ****************
    localparam logic [7:0] ADDR_CFG0    = 8'h00;
    localparam logic [7:0] ADDR_WIDTH0  = 8'h04;
    localparam logic [7:0] ADDR_CFG1    = 8'h08;
    localparam logic [7:0] ADDR_WIDTH1  = 8'h0c;
    localparam logic [7:0] ADDR_STATUS  = 8'h10;
    localparam logic [7:0] CH_STRIDE    = 8'h08;

    // ****************
    // Field positions
    // ****************
    localparam int CFG_ACTION_LSB   = 0;
    localparam int CFG_MODE_BIT     = 3;
    localparam int CFG_SOURCE_LSB   = 4;
    localparam int CFG_QUANTUM_LSB  = 6;
    localparam int CFG_LIMIT_LSB    = 8;
    localparam int CFG_REMOTE_BIT   = 12;
    localparam int CFG_PULSES_LSB   = 16;
    localparam int WIDTH_MS_LSB     = 0;
    localparam int STAT_LEVEL_LSB   = 0;
    localparam int STAT_BUSY_LSB    = 2;
    localparam int STAT_ROT_BIT     = 4;

    // ****************
    // Limits and reset values
    // ****************
    localparam logic [9:0] PULSES_MIN   = 10'h001;
    localparam logic [9:0] PULSES_MAX   = 10'h3e7;
    localparam logic [9:0] PULSES_RST   = 10'h001;
    localparam logic [8:0] WIDTH_MS_MIN = 9'h01e;
    localparam logic [8:0] WIDTH_MS_MAX = 9'h1f4;
    localparam logic [8:0] WIDTH_MS_RST = 9'h064;
    localparam logic [3:0] LIMIT_SEL_LOGIC = 4'h0;
    localparam logic [3:0] LIMIT_SEL_MAX   = 4'hc;
    localparam logic [15:0] PENDING_MAX    = 16'hffff;

    typedef enum logic [2:0] {
        ACT_OFF              = 3'h0,
        ACT_DEVICE_ON        = 3'h1,
        ACT_REMOTE           = 3'h2,
        ACT_ROTATION         = 3'h3,
        ACT_SYNC             = 3'h4,
        ACT_THRESHOLD_BREACH = 3'h5,
        ACT_ENERGY_PULSE     = 3'h6
    } action_t;

    typedef enum logic {
        MODE_PULSE = 1'b0,
        MODE_EDGE  = 1'b1
    } mode_t;

    typedef enum logic [1:0] {
        SRC_ACTIVE_ENERGY_IN    = 2'h0,
        SRC_ACTIVE_ENERGY_OUT   = 2'h1,
        SRC_REACTIVE_ENERGY_IN  = 2'h2,
        SRC_REACTIVE_ENERGY_OUT = 2'h3
    } source_t;

    typedef enum logic [1:0] {
        QUANTUM_1    = 2'h0,
        QUANTUM_10   = 2'h1,
        QUANTUM_100  = 2'h2,
        QUANTUM_1000 = 2'h3
    } quantum_t;

    typedef enum logic [1:0] {
        ENG_IDLE   = 2'b00,
        ENG_ACTIVE = 2'b01,
        ENG_GAP    = 2'b11
    } eng_state_t;

    typedef struct packed {
        action_t    action;
        mode_t      mode;
        source_t    source;
        quantum_t   quantum;
        logic [3:0] limit_sel;
        logic       remote_level;
        logic [9:0] pulses;
        logic [8:0] width_ms;
    } ch_cfg_t;

    localparam ch_cfg_t CFG_RST = '{
        action:       ACT_OFF,
        mode:         MODE_PULSE,
        source:       SRC_ACTIVE_ENERGY_IN,
        quantum:      QUANTUM_1,
        limit_sel:    LIMIT_SEL_LOGIC,
        remote_level: 1'b0,
        pulses:       PULSES_RST,
        width_ms:     WIDTH_MS_RST
    };

    function automatic logic [9:0] quantum_ticks(input quantum_t q);
        logic [9:0] n;
        n = 10'h001;
        unique case (q)
            QUANTUM_1:    n = 10'h001;
            QUANTUM_10:   n = 10'h00a;
            QUANTUM_100:  n = 10'h064;
            QUANTUM_1000: n = 10'h3e8;
        endcase
        return n;
    endfunction

endpackage

/* File: rtl/level_sync.sv */
`timescale 1ns/1ps
module level_sync
    import dout_pkg::*;
(
    input  wire logic i_core_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_async,
    output logic      o_sync
);
    logic stage1;
    logic next_stage1;
    logic next_sync;

    always_comb begin
        next_stage1 = i_async;
        next_sync   = stage1;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            stage1 <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            stage1 <= next_stage1;
            o_sync <= next_sync;
        end
    end
endmodule

/* File: rtl/pulse_engine.sv */
`timescale 1ns/1ps
module pulse_engine
    import dout_pkg::*;
#(
    parameter int P_CYCLES_PER_MS = CYCLES_PER_MS
)(
    input  wire logic                   i_core_clk,
    input  wire logic                   i_sys_rst,
    input  wire ch_cfg_t                i_cfg,
    input  wire logic [NUM_SOURCES-1:0] i_energy_tick,
    output logic                        o_level,
    output logic                        o_busy
);
    localparam int PW = $clog2(P_CYCLES_PER_MS + 1);
    localparam logic [PW-1:0] PRESC_LAST = PW'(P_CYCLES_PER_MS - 1);

    eng_state_t  state;
    eng_state_t  next_state;
    logic [9:0]  qcount;
    logic [9:0]  next_qcount;
    logic [15:0] pending;
    logic [15:0] next_pending;
    logic [PW-1:0] presc;
    logic [PW-1:0] next_presc;
    logic [8:0]  ms_cnt;
    logic [8:0]  next_ms_cnt;
    logic [8:0]  width_lat;
    logic [8:0]  next_width_lat;
    logic        next_level;
    logic        enabled;
    logic        tick;
    logic        quantum_done;
    logic        ms_tick;
    logic        phase_end;
    logic        take;
    logic [16:0] sum;

    always_comb begin
        enabled      = (i_cfg.action == ACT_ENERGY_PULSE);
        tick         = i_energy_tick[i_cfg.source];                        // RQ11
        quantum_done = tick && (qcount == quantum_ticks(i_cfg.quantum) - 10'h001); // RQ12
        ms_tick      = (presc == PRESC_LAST);
        phase_end    = ms_tick && (ms_cnt == width_lat - 9'h001);           // RQ14
        take         = (state == ENG_IDLE) && (pending != 16'h0000);
        next_state     = state;
        next_qcount    = qcount;
        next_presc     = presc;
        next_ms_cnt    = ms_cnt;
        next_width_lat = width_lat;
        next_level     = o_level;
        // Quantum counter wraps once per energy quantum
        if (tick) begin
            next_qcount = quantum_done ? 10'h000 : qcount + 10'h001;
        end
        // Backlog grows by the pulse count, shrinks by one per emission
        sum = {1'b0, pending} + (quantum_done ? {7'h00, i_cfg.pulses} : 17'h00000)
              - (take ? 17'h00001 : 17'h00000);                            // RQ9 RQ13
        next_pending = sum[16] ? PENDING_MAX : sum[15:0];                  // RQ16
        if (state != ENG_IDLE) begin
            next_presc = ms_tick ? '0 : presc + PW'(1);
            if (ms_tick) begin
                next_ms_cnt = ms_cnt + 9'h001;
            end
        end
        unique case (state)
            ENG_IDLE: begin
                if (take) begin
                    next_state     = ENG_ACTIVE;
                    next_presc     = '0;
                    next_ms_cnt    = 9'h000;
                    next_width_lat = i_cfg.width_ms;                        // RQ14
                    next_level     = (i_cfg.mode == MODE_EDGE) ? ~o_level : 1'b1; // RQ10
                end
            end
            ENG_ACTIVE: begin
                if (phase_end) begin
                    next_state  = ENG_GAP;
                    next_presc  = '0;
                    next_ms_cnt = 9'h000;
                    if (i_cfg.mode == MODE_PULSE) begin
                        next_level = 1'b0;
                    end
                end
            end
            ENG_GAP: begin
                // Pause as long as the pulse before the next one may start
                if (phase_end) begin
                    next_state = ENG_IDLE;                                  // RQ15
                end
            end
            default: next_state = ENG_IDLE;
        endcase
        if (!enabled) begin
            next_state   = ENG_IDLE;
            next_qcount  = 10'h000;
            next_pending = 16'h0000;
            next_presc   = '0;
            next_ms_cnt  = 9'h000;
            next_level   = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state     <= ENG_IDLE;
            qcount    <= 10'h000;
            pending   <= 16'h0000;
            presc     <= '0;
            ms_cnt    <= 9'h000;
            width_lat <= WIDTH_MS_RST;
            o_level   <= 1'b0;
            o_busy    <= 1'b0;
        end else begin
            state     <= next_state;
            qcount    <= next_qcount;
            pending   <= next_pending;
            presc     <= next_presc;
            ms_cnt    <= next_ms_cnt;
            width_lat <= next_width_lat;
            o_level   <= next_level;
            o_busy    <= (next_state != ENG_IDLE) || (next_pending != 16'h0000);
        end
    end
endmodule

/* File: rtl/digital_output_controller.sv */
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
// Overview of operation
// (RQ1) Two outputs, channel 0 and channel 1, each with its own function and settings.
// (RQ2) The off function, selected after reset, holds the output low.
// (RQ3) The device-on function drives the output high whenever the device runs.
// (RQ4) The remote function drives the output only from the software-written level bit.
// (RQ5) The rotation function drives the output high while a clockwise field is seen.
// (RQ6) The sync function forwards the synchronisation signal to other devices.
// (RQ7) The threshold breach function follows the selected limit exactly while it is violated.
// (RQ8) The limit selector picks the combined result (default) or one of limits 0 to 11.
// (RQ9) The energy function emits the set number of events per quantum of the chosen counter.
// (RQ10) The style bit picks discrete pulses (default) or level changes as events.
// (RQ11) The energy source is one of four accumulators, active import by default.
// (RQ12) The quantum is 1, 10, 100 or 1000 units, 1 by default.
// (RQ13) The events per quantum range from 1 to 999, 1 by default.
// (RQ14) The pulse width ranges from 30 ms to 500 ms, 100 ms by default.
// (RQ15) The pause between events is at least the pulse width.
// (RQ16) Events that arrive faster than they can be sent are counted and sent later.
module digital_output_controller
    import dout_pkg::*;
#(
    parameter int P_CYCLES_PER_MS = CYCLES_PER_MS
)(
    input  wire logic                   i_core_clk,
    input  wire logic                   i_sys_rst,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic                        pready,
    output logic [31:0]                 prdata,
    output logic                        pslverr,
    input  wire logic                   i_rotation_cw,
    input  wire logic                   i_sync_signal,
    input  wire logic                   i_limit_logic,
    input  wire logic [NUM_LIMITS-1:0]  i_limit_flags,
    input  wire logic [NUM_SOURCES-1:0] i_energy_tick,
    output logic [NUM_OUTPUTS-1:0]      o_dout
);

    // ****************
    // Declarations
    // ****************
    ch_cfg_t                cfg [NUM_OUTPUTS];
    ch_cfg_t                next_cfg [NUM_OUTPUTS];
    logic [NUM_OUTPUTS-1:0] eng_level;
    logic [NUM_OUTPUTS-1:0] eng_busy;
    logic [NUM_OUTPUTS-1:0] next_dout;
    logic                   rot_cw;
    logic                   next_pready;
    logic [31:0]            next_prdata;
    logic                   next_pslverr;
    logic                   setup;
    logic                   access_wr;
    logic                   addr_ok;
    logic [31:0]            rd_word;

    // ****************
    // Helpers
    // ****************
    function automatic logic [9:0] clamp_pulses(input logic [9:0] v);
        logic [9:0] r;
        r = v;
        if (v < PULSES_MIN) begin
            r = PULSES_MIN;
        end else if (v > PULSES_MAX) begin
            r = PULSES_MAX;
        end
        return r;
    endfunction

    function automatic logic [8:0] clamp_width(input logic [8:0] v);
        logic [8:0] r;
        r = v;
        if (v < WIDTH_MS_MIN) begin
            r = WIDTH_MS_MIN;
        end else if (v > WIDTH_MS_MAX) begin
            r = WIDTH_MS_MAX;
        end
        return r;
    endfunction

    function automatic logic [31:0] pack_cfg(input ch_cfg_t c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[CFG_ACTION_LSB +: 3]  = c.action;
        w[CFG_MODE_BIT]         = c.mode;
        w[CFG_SOURCE_LSB +: 2]  = c.source;
        w[CFG_QUANTUM_LSB +: 2] = c.quantum;
        w[CFG_LIMIT_LSB +: 4]   = c.limit_sel;
        w[CFG_REMOTE_BIT]       = c.remote_level;
        w[CFG_PULSES_LSB +: 10] = c.pulses;
        return w;
    endfunction

    // ****************
    // Pin synchroniser
    // ****************
    // Rotation sense is asynchronous
    level_sync u_rot_sync (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_async    (i_rotation_cw),
        .o_sync     (rot_cw)
    );

    // ****************
    // APB slave
    // ****************
    // One wait-free access: answer is prepared in setup, shown in access
    always_comb begin
        setup     = psel && !penable;
        access_wr = psel && penable && pready && pwrite;
        addr_ok   = 1'b1;
        rd_word   = 32'h0000_0000;
        unique case (paddr)
            ADDR_CFG0:   rd_word = pack_cfg(cfg[0]);
            ADDR_WIDTH0: rd_word = {23'h000000, cfg[0].width_ms};
            ADDR_CFG1:   rd_word = pack_cfg(cfg[1]);
            ADDR_WIDTH1: rd_word = {23'h000000, cfg[1].width_ms};
            ADDR_STATUS: begin
                rd_word[STAT_LEVEL_LSB +: NUM_OUTPUTS] = o_dout;
                rd_word[STAT_BUSY_LSB +: NUM_OUTPUTS]  = eng_busy;
                rd_word[STAT_ROT_BIT]                  = rot_cw;
            end
            default:     addr_ok = 1'b0;
        endcase
        next_pready  = setup;
        next_prdata  = (setup && !pwrite && addr_ok) ? rd_word : 32'h0000_0000;
        next_pslverr = setup && !addr_ok;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= next_pready;
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // ****************
    // Per-channel configuration registers
    // ****************
    // Out-of-range limit, pulse and width values clamped; the action code is stored as written
    always_comb begin
        for (int ch = 0; ch < NUM_OUTPUTS; ch++) begin
            next_cfg[ch] = cfg[ch];
            if (access_wr && paddr == ADDR_CFG0 + 8'(ch) * CH_STRIDE) begin   // RQ1
                next_cfg[ch].action       = action_t'(pwdata[CFG_ACTION_LSB +: 3]);
                next_cfg[ch].mode         = mode_t'(pwdata[CFG_MODE_BIT]);
                next_cfg[ch].source       = source_t'(pwdata[CFG_SOURCE_LSB +: 2]);
                next_cfg[ch].quantum      = quantum_t'(pwdata[CFG_QUANTUM_LSB +: 2]);
                next_cfg[ch].limit_sel    = (pwdata[CFG_LIMIT_LSB +: 4] > LIMIT_SEL_MAX)
                                            ? LIMIT_SEL_MAX
                                            : pwdata[CFG_LIMIT_LSB +: 4];       // RQ8
                next_cfg[ch].remote_level = pwdata[CFG_REMOTE_BIT];           // RQ4
                next_cfg[ch].pulses       = clamp_pulses(pwdata[CFG_PULSES_LSB +: 10]); // RQ13
            end
            if (access_wr && paddr == ADDR_WIDTH0 + 8'(ch) * CH_STRIDE) begin
                next_cfg[ch].width_ms = clamp_width(pwdata[WIDTH_MS_LSB +: 9]); // RQ14
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            for (int ch = 0; ch < NUM_OUTPUTS; ch++) begin
                cfg[ch] <= CFG_RST;                                           // RQ2
            end
        end else begin
            for (int ch = 0; ch < NUM_OUTPUTS; ch++) begin
                cfg[ch] <= next_cfg[ch];
            end
        end
    end

    // ****************
    // Energy pulse engines
    // ****************
    for (genvar g = 0; g < NUM_OUTPUTS; g++) begin : g_eng
        pulse_engine #(
            .P_CYCLES_PER_MS (P_CYCLES_PER_MS)
        ) u_eng (
            .i_core_clk    (i_core_clk),
            .i_sys_rst     (i_sys_rst),
            .i_cfg         (cfg[g]),
            .i_energy_tick (i_energy_tick),
            .o_level       (eng_level[g]),
            .o_busy        (eng_busy[g])
        );
    end

    // ****************
    // Output function select
    // ****************
    always_comb begin
        for (int ch = 0; ch < NUM_OUTPUTS; ch++) begin
            next_dout[ch] = 1'b0;
            unique case (cfg[ch].action)
                ACT_OFF:          next_dout[ch] = 1'b0;                       // RQ2
                ACT_DEVICE_ON:    next_dout[ch] = 1'b1;                       // RQ3
                ACT_REMOTE:       next_dout[ch] = cfg[ch].remote_level;       // RQ4
                ACT_ROTATION:     next_dout[ch] = rot_cw;                     // RQ5
                ACT_SYNC:         next_dout[ch] = i_sync_signal;              // RQ6
                ACT_THRESHOLD_BREACH: begin
                    if (cfg[ch].limit_sel == LIMIT_SEL_LOGIC) begin
                        next_dout[ch] = i_limit_logic;                        // RQ7 RQ8
                    end else begin
                        next_dout[ch] = i_limit_flags[cfg[ch].limit_sel - 4'h1]; // RQ7 RQ8
                    end
                end
                ACT_ENERGY_PULSE: next_dout[ch] = eng_level[ch];              // RQ9
                default:          next_dout[ch] = 1'b0;
            endcase
        end
    end

    // Costs one cycle of latency but keeps the pins glitch-free
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_dout <= '0;
        end else begin
            o_dout <= next_dout;
        end
    end

endmodule

/* File: test/dout_chk.sv */
`timescale 1ns/1ps
module dout_chk
    import dout_pkg::*;
#(
    parameter int P_CYCLES_PER_MS = CYCLES_PER_MS
)(
    input wire logic                   i_core_clk,
    input wire logic                   i_sys_rst,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [7:0]             paddr,
    input wire logic [31:0]            pwdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic                   i_sync_signal,
    input wire logic                   i_limit_logic,
    input wire logic [NUM_LIMITS-1:0]  i_limit_flags,
    input wire logic [NUM_OUTPUTS-1:0] o_dout
);
    // Shadow of channel 0 settings and run length of its level
    ch_cfg_t     cfg, next_cfg;
    logic [15:0] run, next_run;
    logic        lv, brk, wr;
    int          wcyc;
    assign wr = psel && penable && pready && pwrite;
    assign wcyc = int'(cfg.width_ms) * P_CYCLES_PER_MS;
    always_comb begin
        next_cfg = cfg;
        if (wr && paddr == ADDR_CFG0) begin
            next_cfg.action       = action_t'(pwdata[2:0]);
            next_cfg.mode         = mode_t'(pwdata[CFG_MODE_BIT]);
            next_cfg.limit_sel    = pwdata[11:8];
            next_cfg.remote_level = pwdata[CFG_REMOTE_BIT];
        end
        if (wr && paddr == ADDR_WIDTH0)
            next_cfg.width_ms = pwdata[8:0];
        // Saturated outside energy function
        next_run = run;
        if (cfg.action != ACT_ENERGY_PULSE)
            next_run = 16'hffff;
        else if (o_dout[0] != lv)
            next_run = 16'h0001;
        else if (run != 16'hffff)
            next_run = run + 16'h0001;
        brk = (cfg.limit_sel == 4'h0) ? i_limit_logic : i_limit_flags[cfg.limit_sel - 4'h1];
    end
    always_ff @(posedge i_core_clk) begin
        cfg <= i_sys_rst ? CFG_RST : next_cfg;
        run <= i_sys_rst ? 16'hffff : next_run;
        lv  <= i_sys_rst ? 1'b0 : o_dout[0];
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    sequence held_s(action_t a);
        cfg.action == a && $stable(cfg);
    endsequence
    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_unmapped: assert property (pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > ADDR_STATUS))
        else $error("wrong error flag");
    a_off_low: assert property (held_s(ACT_OFF) |-> !o_dout[0])
        else $error("off output active");
    a_on_high: assert property (held_s(ACT_DEVICE_ON) |-> o_dout[0])
        else $error("device on output low");
    a_remote_level: assert property (held_s(ACT_REMOTE) |-> o_dout[0] == cfg.remote_level)
        else $error("remote level wrong");
    a_sync_follow: assert property (held_s(ACT_SYNC) |-> o_dout[0] == $past(i_sync_signal))
        else $error("sync not forwarded");
    a_breach_follow: assert property (held_s(ACT_THRESHOLD_BREACH) |-> o_dout[0] == $past(brk))
        else $error("breach not followed");
    property pulse_p(logic ev, logic hi);
        cfg.action == ACT_ENERGY_PULSE && cfg.mode == MODE_PULSE && ev |-> hi;
    endproperty
    a_pulse_width: assert property (pulse_p($fell(o_dout[0]), int'(run) == wcyc))
        else $error("pulse width wrong");
    a_gap_min: assert property (pulse_p($rose(o_dout[0]), int'(run) >= wcyc))
        else $error("pulse gap short");
    c_pulse: cover property (cfg.action == ACT_ENERGY_PULSE && $rose(o_dout[0]));
    c_breach: cover property (cfg.action == ACT_THRESHOLD_BREACH && o_dout[0]);
    c_err: cover property (pready && pslverr);
endmodule
bind digital_output_controller dout_chk #(.P_CYCLES_PER_MS(P_CYCLES_PER_MS)) u_chk (
    .i_core_clk, .i_sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .i_sync_signal, .i_limit_logic, .i_limit_flags, .o_dout);

/* File: test/pulse_counter.sv */
`timescale 1ns/1ps
module pulse_counter (
    input  wire logic i_core_clk,
    input  wire logic i_line,
    output int        o_pulses,
    output int        o_edges,
    output int        o_high
);
    // Only samples, never drives
    logic lv = 1'b0;
    int   run = 0;
    initial begin
        o_pulses = 0;
        o_edges = 0;
        o_high = 0;
    end
    always @(posedge i_core_clk) begin
        if (i_line === 1'b1 && lv === 1'b0)
            o_pulses <= o_pulses + 1;
        if (i_line !== lv)
            o_edges <= o_edges + 1;
        if (i_line === 1'b0 && lv === 1'b1)
            o_high <= run;
        run <= (i_line === 1'b1) ? run + 1 : 0;
        lv <= i_line;
    end
endmodule

/* File: test/test_digital_output_controller.sv */
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin bad_count++; \
    $display("ERROR %s expected %0h seen %0h", n, e, s); end end
module test_digital_output_controller;
    import dout_pkg::*;
    localparam int P = 1;
    logic                   i_core_clk = 1'b0, i_sys_rst = 1'b1;
    logic                   psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
    logic [7:0]             paddr = 8'h00;
    logic [31:0]            pwdata = 32'h0, prdata, q;
    logic                   i_rotation_cw = 1'b0, i_sync_signal = 1'b0, i_limit_logic = 1'b0;
    logic [NUM_LIMITS-1:0]  i_limit_flags = 12'h000;
    logic [NUM_SOURCES-1:0] i_energy_tick = 4'h0;
    logic [NUM_OUTPUTS-1:0] o_dout;
    int                     bad_count = 0, compares = 0, cycles = 0, base, np, ne, nh;
    digital_output_controller #(.P_CYCLES_PER_MS(P)) dut (.i_core_clk, .i_sys_rst, .psel,
        .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .i_rotation_cw,
        .i_sync_signal, .i_limit_logic, .i_limit_flags, .i_energy_tick, .o_dout);
    pulse_counter meter (.i_core_clk, .i_line(o_dout[0]), .o_pulses(np), .o_edges(ne),
        .o_high(nh));
    initial forever #25 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_core_clk);
        penable <= 1'b1;
        @(posedge i_core_clk);
        while (pready !== 1'b1 && n++ < 16) @(posedge i_core_clk);
        `CHK("pready", 1'b1, pready)
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge i_core_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        apb(1'b0, a, 32'h0);
        `CHK("prdata", x, q)
        `CHK("pslverr", xe, e)
    endtask
    task automatic ck(input int n, input logic [1:0] x);
        cyc(n);
        `CHK("o_dout", x, o_dout)
    endtask
    task automatic tick(input logic [3:0] b, input int n);
        repeat (n) begin
            i_energy_tick <= b;
            @(posedge i_core_clk);
            i_energy_tick <= 4'h0;
            @(posedge i_core_clk);
        end
    endtask
    task automatic t_levels();
        rd(ADDR_CFG0, 32'h0001_0000, 1'b0);
        rd(ADDR_WIDTH1, 32'h0000_0064, 1'b0);
        rd(8'h14, 32'h0, 1'b1);
        apb(1'b1, ADDR_CFG0, 32'h1);
        apb(1'b1, ADDR_CFG1, 32'h1002);
        ck(2, 2'b11);
        rd(ADDR_STATUS, 32'h3, 1'b0);
        apb(1'b1, ADDR_CFG1, 32'h2);
        apb(1'b1, ADDR_CFG0, 32'h4);
        i_sync_signal <= 1'b1;
        ck(2, 2'b01);
        i_sync_signal <= 1'b0;
        ck(2, 2'b00);
        i_limit_flags <= 12'h800;
        apb(1'b1, ADDR_CFG0, 32'h5);
        ck(2, 2'b00);
        i_limit_logic <= 1'b1;
        ck(2, 2'b01);
        i_limit_flags <= 12'h7ff;
        apb(1'b1, ADDR_CFG0, 32'hc05);
        ck(2, 2'b00);
        i_limit_flags <= 12'h800;
        ck(2, 2'b01);
        apb(1'b1, ADDR_CFG0, 32'h0);
        apb(1'b1, ADDR_CFG1, 32'h3);
        i_rotation_cw <= 1'b1;
        ck(6, 2'b10);
        rd(ADDR_STATUS, 32'h12, 1'b0);
        i_rotation_cw <= 1'b0;
        ck(6, 2'b00);
        apb(1'b1, ADDR_CFG1, 32'h0);
        $display("test levels done");
    endtask
    task automatic t_energy();
        apb(1'b1, ADDR_WIDTH0, 32'h1e);
        for (int s = 0; s < NUM_SOURCES; s++) begin
            apb(1'b1, ADDR_CFG0, 32'h0001_0006 | (s << 4));
            base = np;
            tick(~(4'h1 << s), 1);
            cyc(80);
            `CHK("other source", base, np)
            tick(4'h1 << s, 2);
            cyc(150);
            `CHK("pulses", base + 2, np)
            `CHK("width", 30 * P, nh)
        end
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, ADDR_CFG0, 32'h0002_0006 | (k << 6));
            base = np;
            tick(4'h1, 10 ** k - 1);
            cyc(10);
            `CHK("early", base, np)
            tick(4'h1, 1);
            cyc(150);
            `CHK("per quantum", base + 2, np)
        end
        apb(1'b1, ADDR_CFG0, 32'h0003_000e);
        base = ne;
        tick(4'h1, 1);
        cyc(250);
        `CHK("edges", base + 3, ne)
        apb(1'b1, ADDR_CFG0, 32'h0);
        apb(1'b1, ADDR_WIDTH0, 32'h1f4);
        apb(1'b1, ADDR_CFG0, 32'h0001_0006);
        tick(4'h1, 1);
        cyc(1100);
        `CHK("long width", 500 * P, nh)
        apb(1'b1, ADDR_CFG0, 32'h0);
        ck(2, 2'b00);
        $display("test energy done");
    endtask
    initial begin
        cyc(3);
        i_sys_rst <= 1'b0;
        @(posedge i_core_clk);
        t_levels();
        t_energy();
        stop_test();
    end
endmodule
